// ===== pioc_top.sv
// Purpose: APB bank of pad control registers driving the pad cells.
// Assumes: APB3/APB4 master; pad inputs synchronous to pclk.
// Notes: Pad outputs are registered, so a control write shows one cycle
//   after the APB access completes.
`timescale 1ns/100ps
`default_nettype none
module pioc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pioc_pkg::NFUNC-1:0] func_out [pioc_pkg::NPAD],
  input wire logic [pioc_pkg::NFUNC-1:0] func_oe [pioc_pkg::NPAD],
  input wire logic [pioc_pkg::NPAD-1:0] pad_in,
  output var pioc_pkg::pioc_drive_s pad_drive [pioc_pkg::NPAD],
  output logic [pioc_pkg::NPAD-1:0] core_in
);

  pioc_pkg::pioc_ctl_s ctl_q [pioc_pkg::NPAD];
  pioc_pkg::pioc_drive_s drive_d [pioc_pkg::NPAD];
  logic [pioc_pkg::NPAD-1:0] core_in_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic hit;
  logic [pioc_pkg::IDXW-1:0] idx;
  logic setup;
  logic wr_en;
  logic [pioc_pkg::CTLW-1:0] wr_mask;
  logic run_q;
  logic wrote0_q;

  assign setup = psel && !penable;
  // A write lands only at the edge where the access completes
  assign wr_en = psel && penable && pready_q && pwrite && hit;

  always_comb begin
    wr_mask = '0;
    for (int b = 0; b < pioc_pkg::CTLW; b++) begin
      if (b <= pioc_pkg::LANE0_HI) begin
        wr_mask[b] = pstrb[0];
      end else begin
        wr_mask[b] = pstrb[1];
      end
    end
  end

  pioc_decode u_decode (
    .paddr(paddr),
    .hit(hit),
    .idx(idx)
  );

  genvar g;
  generate
    for (g = 0; g < pioc_pkg::NPAD; g++) begin : g_pad
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_q[g] <= pioc_pkg::CTL_RESET;
        end else if (wr_en && idx == pioc_pkg::IDXW'(g)) begin
          // Upper bits have no storage, so writes there vanish
          ctl_q[g] <= (ctl_q[g] & ~wr_mask) |
                      (pwdata[pioc_pkg::CTLW-1:0] & wr_mask);
        end
      end

      pioc_pad #(
        .OPEN_DRAIN(pioc_pkg::OPEN_DRAIN[g])
      ) u_pad (
        .ctl(ctl_q[g]),
        .func_out(func_out[g]),
        .func_oe(func_oe[g]),
        .pad_in(pad_in[g]),
        .drive(drive_d[g]),
        .core_in(core_in_d[g])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_drive[g] <= pioc_pkg::DRIVE_RESET;
          core_in[g] <= 1'b0;
        end else begin
          pad_drive[g] <= drive_d[g];
          core_in[g] <= core_in_d[g];
        end
      end
    end
  endgenerate

  // Answer one cycle after setup: no wait states, so pready is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !hit;
    end else if (!psel) begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup && !pwrite && hit) begin
      prdata_q <= {{(32-pioc_pkg::CTLW){1'b0}}, ctl_q[idx]};
    end else if (setup) begin
      prdata_q <= '0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Helper state for the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrote0_q <= 1'b0;
    end else if (wr_en && idx == pioc_pkg::IDXW'(pioc_pkg::PAD_HOST_IRQ_LINE)) begin
      wrote0_q <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_func_route;
    run_q |-> pad_drive[0].pad_out ==
      $past(func_out[0][ctl_q[0].function_select_field]);
  endproperty
  a_func_route: assert property (p_func_route)
    else $error("pad output does not follow the selected function");

  property p_reset_word;
    !wrote0_q |-> ctl_q[0] == pioc_pkg::CTL_RESET;
  endproperty
  a_reset_word: assert property (p_reset_word)
    else $error("unwritten pad register left its reset value");

  property p_slew;
    run_q |-> pad_drive[3].slow_slew == $past(ctl_q[3].slew_control_bit);
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew output does not follow its control bit");

  property p_pull_dir;
    run_q && pad_drive[0].pull_up |->
      $past(ctl_q[0].pull_direction_bit) &&
      !$past(ctl_q[0].pull_inhibit_bit);
  endproperty
  a_pull_dir: assert property (p_pull_dir)
    else $error("pullup active without direction set and pulls enabled");

  property p_pull_en;
    run_q |-> pad_drive[0].pull_en != $past(ctl_q[0].pull_inhibit_bit);
  endproperty
  a_pull_en: assert property (p_pull_en)
    else $error("pull enable does not follow the inhibit bit");

  property p_oe_force;
    run_q && $past(ctl_q[0].output_force_on) |->
      pad_drive[0].pad_oe != $past(ctl_q[0].output_force_value);
  endproperty
  a_oe_force: assert property (p_oe_force)
    else $error("forced output enable not applied to pad");

  property p_in_force;
    run_q |-> core_in[0] == ($past(ctl_q[0].input_force_on) ?
      $past(ctl_q[0].input_force_value) : $past(pad_in[0]));
  endproperty
  a_in_force: assert property (p_in_force)
    else $error("core input does not honour the input force bits");

  property p_open_drain;
    !pad_drive[pioc_pkg::PAD_SOFT_RESTART].pad_out &&
    !(pad_drive[pioc_pkg::PAD_FAULT_OUTPUT].pad_out);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pad driven high");

  property p_write_lands;
    psel && penable && pready && pwrite && pstrb == 4'hF &&
      paddr == pioc_pkg::PAD_ADDR[pioc_pkg::PAD_SERIAL_A_DOUT] |=>
      ctl_q[pioc_pkg::PAD_SERIAL_A_DOUT] ==
        $past(pwdata[pioc_pkg::CTLW-1:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write to pad register did not land");

  property p_reserved_zero;
    pready |-> (prdata & pioc_pkg::RESERVED_UPPER_BITS) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read back nonzero");

  property p_one_wait;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("APB answer not exactly one cycle after setup");

  property p_unmapped_err;
    psel && !penable && !hit |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped address not answered with an error");

endmodule
`default_nettype wire

// ===== pioc_pkg.sv
// Purpose: Shared constants and types for the pad control register bank.
// Assumes: One 32-bit word per pad control register, reached over APB.
// Notes: Offsets are full byte addresses in the subsystem memory map.
package pioc_pkg;

  localparam int NPAD = 41;
  localparam int NFUNC = 16;
  localparam int IDXW = 6;
  localparam int CTLW = 11;

  // Pad control word, bit 10 down to bit 0
  typedef struct packed {
    logic slew_control_bit;
    logic pull_direction_bit;
    logic pull_inhibit_bit;
    logic output_force_value;
    logic output_force_on;
    logic input_force_value;
    logic input_force_on;
    logic [3:0] function_select_field;
  } pioc_ctl_s;

  // What one pad cell drives toward the ball
  typedef struct packed {
    logic pad_out;
    logic pad_oe;
    logic pull_en;
    logic pull_up;
    logic slow_slew;
  } pioc_drive_s;

  localparam pioc_ctl_s CTL_RESET = '{
    slew_control_bit: 1'h0,
    pull_direction_bit: 1'h0,
    pull_inhibit_bit: 1'h0,
    output_force_value: 1'h1,
    output_force_on: 1'h1,
    input_force_value: 1'h0,
    input_force_on: 1'h0,
    function_select_field: 4'h1
  };

  localparam pioc_drive_s DRIVE_RESET = '{
    pad_out: 1'h0,
    pad_oe: 1'h0,
    pull_en: 1'h1,
    pull_up: 1'h0,
    slow_slew: 1'h0
  };

  localparam logic [31:0] RESERVED_UPPER_BITS = 32'hFFFFF800;
  localparam int LANE0_HI = 7;
  localparam int LANE1_LO = 8;

  localparam int PAD_HOST_IRQ_LINE = 0;
  localparam int PAD_SERIAL_A_DOUT = 3;
  localparam int PAD_SOFT_RESTART = 18;
  localparam int PAD_FAULT_OUTPUT = 19;

  // Pads whose driver may only pull low
  localparam logic [NPAD-1:0] OPEN_DRAIN =
    (41'h1 << PAD_SOFT_RESTART) | (41'h1 << PAD_FAULT_OUTPUT);

  localparam logic [31:0] PAD_ADDR [NPAD] = '{
    32'hFFFFEA00, 32'hFFFFEA04, 32'hFFFFEA08, 32'hFFFFEA0C,
    32'hFFFFEA10, 32'hFFFFEA14, 32'hFFFFEA18, 32'hFFFFEA1C,
    32'hFFFFEA20, 32'hFFFFEA24, 32'hFFFFEA28, 32'hFFFFEA2C,
    32'hFFFFEA30, 32'hFFFFEA34, 32'hFFFFEA38, 32'hFFFFEA3C,
    32'hFFFFEA40, 32'hFFFFEA44, 32'hFFFFEA48, 32'hFFFFEA4C,
    32'hFFFFEA50, 32'hFFFFEA54, 32'hFFFFEA58, 32'hFFFFEA5C,
    32'hFFFFEA60, 32'hFFFFEA64, 32'hFFFFEA68, 32'h0FFFEA6C,
    32'hFFFFEA70, 32'hFFFFEA74, 32'hFFFFEA78, 32'hFFFFEA7C,
    32'hFFFFEA80, 32'hFFFFEA84, 32'hFFFFEA88, 32'hFFFFEA8C,
    32'hFFFFEA90, 32'hFFFFEA94, 32'hFFFFEA98, 32'hFFFFEABC,
    32'hFFFFEAC0
  };

endpackage

// ===== pioc_decode.sv
// Purpose: Match an APB address against the pad register map.
// Assumes: Addresses in the map are distinct.
// Notes: Purely combinational; index is zero on a miss.
`timescale 1ns/100ps
`default_nettype none
module pioc_decode (
  input wire logic [31:0] paddr,
  output logic hit,
  output logic [pioc_pkg::IDXW-1:0] idx
);

  logic [pioc_pkg::NPAD-1:0] match;

  genvar g;
  generate
    for (g = 0; g < pioc_pkg::NPAD; g++) begin : g_match
      assign match[g] = (paddr == pioc_pkg::PAD_ADDR[g]);
    end
  endgenerate

  always_comb begin
    idx = '0;
    for (int i = 0; i < pioc_pkg::NPAD; i++) begin
      if (match[i]) begin
        idx = pioc_pkg::IDXW'(i);
      end
    end
  end

  assign hit = |match;

endmodule
`default_nettype wire

// ===== pioc_pad.sv
// Purpose: Combinational pad cell steered by one pad control word.
// Assumes: Peripherals give one output and one output enable per function.
// Notes: Open-drain pads never drive high, whatever the function asks.
`timescale 1ns/100ps
`default_nettype none
module pioc_pad #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire pioc_pkg::pioc_ctl_s ctl,
  input wire logic [pioc_pkg::NFUNC-1:0] func_out,
  input wire logic [pioc_pkg::NFUNC-1:0] func_oe,
  input wire logic pad_in,
  output var pioc_pkg::pioc_drive_s drive,
  output logic core_in
);

  logic sel_out;
  logic sel_oe;

  always_comb begin
    sel_out = func_out[ctl.function_select_field];
    // Force value 1 keeps the driver off, so reset leaves pads undriven
    sel_oe = ctl.output_force_on ? !ctl.output_force_value
                                 : func_oe[ctl.function_select_field];
    drive.slow_slew = ctl.slew_control_bit;
    drive.pull_en = !ctl.pull_inhibit_bit;
    drive.pull_up = ctl.pull_direction_bit && !ctl.pull_inhibit_bit;
    if (OPEN_DRAIN) begin
      drive.pad_out = 1'b0;
      drive.pad_oe = sel_oe && !sel_out;
    end else begin
      drive.pad_out = sel_out;
      drive.pad_oe = sel_oe;
    end
  end

  assign core_in = ctl.input_force_on ? ctl.input_force_value : pad_in;

endmodule
`default_nettype wire

// ===== pioc_tb.sv
// Purpose: Self-checking bench for the pad control register bank.
// Assumes: Wait-free APB slave; pad outputs lag a register write by a cycle.
// Notes: Assertions live in the design files; this bench drives ports and checks prdata, pslverr, pad_drive and core_in.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int NP = pioc_pkg::NPAD;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] kb;
  logic [pioc_pkg::NFUNC-1:0] func_out [NP];
  logic [pioc_pkg::NFUNC-1:0] func_oe [NP];
  logic [NP-1:0] pad_in, core_in;
  pioc_pkg::pioc_drive_s pad_drive [NP];
  int errors, checks_done;

  pioc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .func_out(func_out), .func_oe(func_oe), .pad_in(pad_in),
    .pad_drive(pad_drive), .core_in(core_in)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until pready is sampled high at a rising edge, then released
  task automatic apb(input logic w, input logic [31:0] a, d,
      input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pad outputs are registered from the control word, so let two edges pass
  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask

  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 4'hF);
    settle();
  endtask

  task automatic rdc(input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0, 4'h0);
    check("prdata", rd, exp);
  endtask

  task automatic dchk(input int p, input logic [4:0] e);
    check("pad_drive", {27'h0, pad_drive[p]}, {27'h0, e});
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pad_in = '0;
    kb = 3'h0;
    for (int p = 0; p < NP; p++) begin
      func_out[p] = 16'h0;
      func_oe[p] = 16'h0;
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    dchk(18, 5'b00100);
    dchk(0, 5'b00100);
    for (int p = 0; p < NP; p++) begin
      rdc(pioc_pkg::PAD_ADDR[p], 32'h000000C1);
    end
    apb(1'b0, 32'hFFFFEA9C, 32'h0, 4'h0);
    check("pslverr", {31'h0, er}, 32'h1);
    check("prdata", rd, 32'h0);
    wr(pioc_pkg::PAD_ADDR[5], 32'hFFFFFFFF);
    rdc(pioc_pkg::PAD_ADDR[5], 32'h000007FF);
    rdc(pioc_pkg::PAD_ADDR[4], 32'h000000C1);
    apb(1'b1, pioc_pkg::PAD_ADDR[2], 32'h000007FF, 4'h1);
    rdc(pioc_pkg::PAD_ADDR[2], 32'h000000FF);
    // One-hot peripheral lines expose any wrong function index
    for (int f = 0; f < 16; f++) begin
      @(posedge pclk);
      func_out[3] <= 16'h1 << f;
      func_oe[3] <= 16'h1 << f;
      wr(pioc_pkg::PAD_ADDR[3], {28'h0, 4'(f)});
      dchk(3, 5'b11100);
    end
    for (int k = 0; k < 8; k++) begin
      kb = 3'(k);
      wr(pioc_pkg::PAD_ADDR[0], {21'h0, kb, 8'h01});
      dchk(0, {2'b00, ~kb[0], kb[1] & ~kb[0], kb[2]});
    end
    @(posedge pclk);
    func_out[1] <= 16'h0002;
    func_oe[1] <= 16'h0000;
    wr(pioc_pkg::PAD_ADDR[1], 32'h00000041);
    dchk(1, 5'b11100);
    wr(pioc_pkg::PAD_ADDR[1], 32'h000000C1);
    dchk(1, 5'b10100);
    @(posedge pclk);
    func_oe[1] <= 16'h0002;
    wr(pioc_pkg::PAD_ADDR[1], 32'h00000001);
    dchk(1, 5'b11100);
    wr(pioc_pkg::PAD_ADDR[1], 32'h00000031);
    check("core_in", {31'h0, core_in[1]}, 32'h1);
    wr(pioc_pkg::PAD_ADDR[1], 32'h00000021);
    check("core_in", {31'h0, core_in[1]}, 32'h0);
    @(posedge pclk);
    pad_in[1] <= 1'b1;
    settle();
    check("core_in", {31'h0, core_in[1]}, 32'h1);
    wr(pioc_pkg::PAD_ADDR[1], 32'h00000011);
    check("core_in", {31'h0, core_in[1]}, 32'h0);
    @(posedge pclk);
    func_out[19] <= 16'hFFFF;
    func_oe[19] <= 16'hFFFF;
    wr(pioc_pkg::PAD_ADDR[19], 32'h00000002);
    dchk(19, 5'b00100);
    @(posedge pclk);
    func_out[19] <= 16'h0000;
    settle();
    dchk(19, 5'b01100);
    stop_test();
  end
endmodule
`default_nettype wire
